/* rcw_consts.svh */
// Constants for the calendar clock control word block: offsets, fields, resets and counts
`ifndef RCW_CONSTS_SVH
`define RCW_CONSTS_SVH

`define RCW_ADDR_W 8
`define RCW_DATA_W 32

`define RCW_OFS_CTRL_LOW 8'h00
`define RCW_OFS_CTRL_TWO 8'h04
`define RCW_OFS_KEY 8'h08
`define RCW_OFS_TIME 8'h0c
`define RCW_OFS_IRQ_STATUS 8'h10
`define RCW_OFS_IRQ_MASK 8'h14
`define RCW_OFS_ALARM 8'h18
`define RCW_OFS_STAMP 8'h1c

`define RCW_CTRL_LOW_RESET 16'h0000
`define RCW_CTRL_LOW_WMASK 16'h8ff1
`define RCW_CTRL_TWO_RESET 2'h0
`define RCW_IRQ_W 4
`define RCW_IRQ_SECOND 0
`define RCW_IRQ_ALARM 1
`define RCW_IRQ_STAMP 2
`define RCW_IRQ_POWER 3

`define RCW_KEY_FIRST 8'h55
`define RCW_KEY_SECOND 8'haa
`define RCW_UNLOCK_WINDOW_CYC 4'h4

`define RCW_PIN_N 4
`define RCW_PIN_CRYSTAL 0
`define RCW_PIN_LOW_POWER_RC_OSC 1
`define RCW_PIN_MAINS 2
`define RCW_PIN_STAMP 3

`define RCW_TICKS_CRYSTAL 32'd32768
`define RCW_TICKS_LOW_POWER_RC_OSC 32'd31250
`define RCW_TICKS_MAINS 32'd50
`define RCW_SYS_CLK_HZ 250000000

`endif

/* rcw_pkg.sv */
// Types shared by the calendar clock control word block
package rcw_pkg;

	typedef struct packed {
		logic run_enable;
		logic [2:0] rsv_hi;
		logic register_write_lock;
		logic power_ctl_function_enable;
		logic power_ctl_polarity;
		logic power_ctl_pin_enable;
		logic clock_output_enable;
		logic [2:0] output_event_select;
		logic [2:0] rsv_lo;
		logic capture_a_enable;
	} rcw_ctrl_low_type;

	typedef enum logic [1:0] {
		RCW_SRC_CRYSTAL,
		RCW_SRC_LOW_POWER_RC_OSC,
		RCW_SRC_MAINS,
		RCW_SRC_SYSTEM
	} rcw_source_type;

	typedef enum logic [2:0] {
		RCW_OUT_ALARM,
		RCW_OUT_SECOND,
		RCW_OUT_INPUT,
		RCW_OUT_POWER,
		RCW_OUT_STAMP,
		RCW_OUT_UNUSED5,
		RCW_OUT_UNUSED6,
		RCW_OUT_UNUSED7
	} rcw_out_sel_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} rcw_bus_req_type;

endpackage

/* rcw_unlock_seq.sv */
// Key sequence tracker that opens a short window for clearing the write lock
`timescale 1ns/100ps
`include "rcw_consts.svh"

module rcw_unlock_seq (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic any_write,
	input wire logic key_write,
	input wire logic [7:0] key_data,
	output logic unlock_open
);

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_GOT_FIRST,
		KEY_OPEN
	} rcw_key_state_type;

	rcw_key_state_type state_reg;
	rcw_key_state_type state_next;
	logic [3:0] window_reg;
	logic [3:0] window_next;

	always_comb begin
		state_next = state_reg;
		window_next = window_reg;
		unique case (state_reg)
			KEY_IDLE: begin
				if (key_write && key_data == `RCW_KEY_FIRST) begin
					state_next = KEY_GOT_FIRST;
				end
			end
			KEY_GOT_FIRST: begin
				// The two key bytes must be consecutive writes
				if (any_write) begin
					if (key_write && key_data == `RCW_KEY_SECOND) begin
						state_next = KEY_OPEN;
						window_next = `RCW_UNLOCK_WINDOW_CYC;
					end else if (key_write && key_data == `RCW_KEY_FIRST) begin
						state_next = KEY_GOT_FIRST;
					end else begin
						state_next = KEY_IDLE;
					end
				end
			end
			KEY_OPEN: begin
				// The next write of any kind uses the window up, as does a timeout
				if (any_write || window_reg == 4'h1) begin
					state_next = KEY_IDLE;
					window_next = 4'h0;
				end else begin
					window_next = window_reg - 4'h1;
				end
			end
			default: begin
				state_next = KEY_IDLE;
				window_next = 4'h0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= KEY_IDLE;
			window_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			window_reg <= window_next;
		end
	end

	assign unlock_open = (state_reg == KEY_OPEN);

endmodule

/* rcw_top.sv */
// Calendar clock low control word with lock, event output, counter and interrupts
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/100ps
`include "rcw_consts.svh"

module rcw_top #(
	parameter logic [31:0] SYS_TICKS_PER_SEC = `RCW_SYS_CLK_HZ
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input rcw_pkg::rcw_bus_req_type bus_req,
	output logic [31:0] bus_rdata,
	input wire logic crystal_clk_pin,
	input wire logic low_power_rc_osc_clk_pin,
	input wire logic mains_clk_pin,
	input wire logic stamp_n_pin,
	output logic clock_out,
	output logic clock_out_oe,
	output logic power_ctl_out,
	output logic power_ctl_out_oe,
	output logic irq
);

	// Reset release
	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// Pin synchronisers: a change counts once the second and third stages agree
	logic [`RCW_PIN_N-1:0] pin_raw;
	logic [`RCW_PIN_N-1:0] pin_s1_reg;
	logic [`RCW_PIN_N-1:0] pin_s2_reg;
	logic [`RCW_PIN_N-1:0] pin_s3_reg;
	logic [`RCW_PIN_N-1:0] pin_lvl_reg;
	logic [`RCW_PIN_N-1:0] pin_lvl_next;
	logic [`RCW_PIN_N-1:0] pin_rise;
	logic [`RCW_PIN_N-1:0] pin_fall;

	assign pin_raw[`RCW_PIN_CRYSTAL] = crystal_clk_pin;
	assign pin_raw[`RCW_PIN_LOW_POWER_RC_OSC] = low_power_rc_osc_clk_pin;
	assign pin_raw[`RCW_PIN_MAINS] = mains_clk_pin;
	assign pin_raw[`RCW_PIN_STAMP] = stamp_n_pin;

	genvar gi;
	generate
		for (gi = 0; gi < `RCW_PIN_N; gi = gi + 1) begin : g_pin
			always_comb begin
				pin_lvl_next[gi] = pin_lvl_reg[gi];
				if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
					pin_lvl_next[gi] = pin_s3_reg[gi];
				end
			end
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					pin_s1_reg[gi] <= 1'b0;
					pin_s2_reg[gi] <= 1'b0;
					pin_s3_reg[gi] <= 1'b0;
					pin_lvl_reg[gi] <= 1'b0;
				end else begin
					pin_s1_reg[gi] <= pin_raw[gi];
					pin_s2_reg[gi] <= pin_s1_reg[gi];
					pin_s3_reg[gi] <= pin_s2_reg[gi];
					pin_lvl_reg[gi] <= pin_lvl_next[gi];
				end
			end
			assign pin_rise[gi] = pin_lvl_next[gi] && !pin_lvl_reg[gi];
			assign pin_fall[gi] = !pin_lvl_next[gi] && pin_lvl_reg[gi];
		end
	endgenerate

	// Bus decode
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	function automatic logic [31:0] ticks_per_sec(input rcw_pkg::rcw_source_type src,
			input logic [31:0] sys_ticks);
		unique case (src)
			rcw_pkg::RCW_SRC_CRYSTAL: ticks_per_sec = `RCW_TICKS_CRYSTAL;
			rcw_pkg::RCW_SRC_LOW_POWER_RC_OSC: ticks_per_sec = `RCW_TICKS_LOW_POWER_RC_OSC;
			rcw_pkg::RCW_SRC_MAINS: ticks_per_sec = `RCW_TICKS_MAINS;
			rcw_pkg::RCW_SRC_SYSTEM: ticks_per_sec = sys_ticks;
		endcase
	endfunction

	logic wr_ctrl_low;
	logic wr_ctrl_two;
	logic wr_key;
	logic wr_time;
	logic wr_status;
	logic wr_mask;
	logic wr_alarm;
	logic unlock_open;

	assign wr_ctrl_low = bus_req.wr && hit(bus_req.addr, `RCW_OFS_CTRL_LOW);
	assign wr_ctrl_two = bus_req.wr && hit(bus_req.addr, `RCW_OFS_CTRL_TWO);
	assign wr_key = bus_req.wr && hit(bus_req.addr, `RCW_OFS_KEY);
	assign wr_time = bus_req.wr && hit(bus_req.addr, `RCW_OFS_TIME);
	assign wr_status = bus_req.wr && hit(bus_req.addr, `RCW_OFS_IRQ_STATUS);
	assign wr_mask = bus_req.wr && hit(bus_req.addr, `RCW_OFS_IRQ_MASK);
	assign wr_alarm = bus_req.wr && hit(bus_req.addr, `RCW_OFS_ALARM);

	rcw_unlock_seq u_unlock (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.any_write(bus_req.wr),
		.key_write(wr_key),
		.key_data(bus_req.wdata[7:0]),
		.unlock_open(unlock_open)
	);

	// Control registers
	rcw_pkg::rcw_ctrl_low_type ctrl_reg;
	rcw_pkg::rcw_ctrl_low_type ctrl_next;
	rcw_pkg::rcw_ctrl_low_type ctrl_wr;
	rcw_pkg::rcw_source_type src_reg;
	rcw_pkg::rcw_source_type src_next;
	logic [31:0] alarm_reg;
	logic [31:0] alarm_next;
	logic [`RCW_IRQ_W-1:0] mask_reg;
	logic [`RCW_IRQ_W-1:0] mask_next;

	assign ctrl_wr = rcw_rcw_cast(bus_req.wdata[15:0]);

	function automatic rcw_pkg::rcw_ctrl_low_type rcw_rcw_cast(input logic [15:0] v);
		rcw_rcw_cast = rcw_pkg::rcw_ctrl_low_type'(v & `RCW_CTRL_LOW_WMASK);
	endfunction

	always_comb begin
		ctrl_next = ctrl_reg;
		src_next = src_reg;
		alarm_next = alarm_reg;
		mask_next = mask_reg;
		if (wr_ctrl_low) begin
			// Power, output and capture fields stay writable under the lock
			ctrl_next = ctrl_wr;
			ctrl_next.run_enable = ctrl_reg.register_write_lock ? ctrl_reg.run_enable :
				ctrl_wr.run_enable;
			if (ctrl_reg.register_write_lock && !ctrl_wr.register_write_lock) begin
				ctrl_next.register_write_lock = !unlock_open;
			end else begin
				ctrl_next.register_write_lock = ctrl_wr.register_write_lock;
			end
		end
		if (wr_ctrl_two && !ctrl_reg.register_write_lock) begin
			src_next = rcw_pkg::rcw_source_type'(bus_req.wdata[1:0]);
		end
		if (wr_alarm) begin
			alarm_next = bus_req.wdata;
		end
		if (wr_mask) begin
			mask_next = bus_req.wdata[`RCW_IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= `RCW_CTRL_LOW_RESET;
			src_reg <= rcw_pkg::RCW_SRC_CRYSTAL;
			alarm_reg <= 32'h0;
			mask_reg <= 4'h0;
		end else begin
			ctrl_reg <= ctrl_next;
			src_reg <= src_next;
			alarm_reg <= alarm_next;
			mask_reg <= mask_next;
		end
	end

	// Time base and seconds counter
	logic [31:0] sub_reg;
	logic [31:0] sub_next;
	logic [31:0] time_reg;
	logic [31:0] time_next;
	logic half_clk_reg;
	logic half_clk_next;
	logic ref_tick;
	logic [31:0] limit;
	logic sec_tick;
	logic half_tick;

	always_comb begin
		unique case (src_reg)
			rcw_pkg::RCW_SRC_CRYSTAL: ref_tick = pin_rise[`RCW_PIN_CRYSTAL];
			rcw_pkg::RCW_SRC_LOW_POWER_RC_OSC: ref_tick = pin_rise[`RCW_PIN_LOW_POWER_RC_OSC];
			rcw_pkg::RCW_SRC_MAINS: ref_tick = pin_rise[`RCW_PIN_MAINS];
			rcw_pkg::RCW_SRC_SYSTEM: ref_tick = 1'b1;
		endcase
	end

	assign limit = ticks_per_sec(src_reg, SYS_TICKS_PER_SEC);
	assign sec_tick = ctrl_reg.run_enable && ref_tick && (sub_reg >= limit - 32'h1);
	assign half_tick = ctrl_reg.run_enable && ref_tick && (sub_reg == (limit >> 1) - 32'h1);

	always_comb begin
		sub_next = sub_reg;
		time_next = time_reg;
		half_clk_next = half_clk_reg;
		if (ctrl_reg.run_enable && ref_tick) begin
			sub_next = sec_tick ? 32'h0 : sub_reg + 32'h1;
		end
		if (sec_tick || half_tick) begin
			half_clk_next = !half_clk_reg;
		end
		if (sec_tick) begin
			time_next = time_reg + 32'h1;
		end
		// A software write wins over the count in the same cycle
		if (wr_time && !ctrl_reg.register_write_lock) begin
			time_next = bus_req.wdata;
			sub_next = 32'h0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sub_reg <= 32'h0;
			time_reg <= 32'h0;
			half_clk_reg <= 1'b0;
		end else begin
			sub_reg <= sub_next;
			time_reg <= time_next;
			half_clk_reg <= half_clk_next;
		end
	end

	// Events, timestamp and interrupt status
	logic [`RCW_IRQ_W-1:0] status_reg;
	logic [`RCW_IRQ_W-1:0] status_next;
	logic [`RCW_IRQ_W-1:0] event_vec;
	logic [31:0] stamp_reg;
	logic [31:0] stamp_next;
	logic power_active;
	logic power_prev_reg;
	logic alarm_event;
	logic stamp_event;
	logic irq_reg;
	logic irq_next;

	assign power_active = ctrl_reg.power_ctl_function_enable;
	assign alarm_event = sec_tick && (time_next == alarm_reg);
	assign stamp_event = ctrl_reg.capture_a_enable && pin_fall[`RCW_PIN_STAMP];

	always_comb begin
		event_vec = '0;
		event_vec[`RCW_IRQ_SECOND] = sec_tick;
		event_vec[`RCW_IRQ_ALARM] = alarm_event;
		event_vec[`RCW_IRQ_STAMP] = stamp_event;
		event_vec[`RCW_IRQ_POWER] = power_active && !power_prev_reg;
		stamp_next = stamp_event ? time_reg : stamp_reg;
		// Clearing by a written one; a new event in the same cycle keeps its bit
		status_next = status_reg;
		if (wr_status) begin
			status_next = status_reg & ~bus_req.wdata[`RCW_IRQ_W-1:0];
		end
		status_next = status_next | event_vec;
		irq_next = |(status_next & mask_next);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= 4'h0;
			stamp_reg <= 32'h0;
			power_prev_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			stamp_reg <= stamp_next;
			power_prev_reg <= power_active;
			irq_reg <= irq_next;
		end
	end

	// Pin outputs
	logic clk_out_reg;
	logic clk_out_next;
	logic clk_oe_reg;
	logic pwc_reg;
	logic pwc_next;
	logic pwc_oe_reg;

	always_comb begin
		unique case (rcw_pkg::rcw_out_sel_type'(ctrl_next.output_event_select))
			rcw_pkg::RCW_OUT_ALARM: clk_out_next = alarm_event;
			rcw_pkg::RCW_OUT_SECOND: clk_out_next = half_clk_next;
			rcw_pkg::RCW_OUT_INPUT: clk_out_next = ref_tick;
			rcw_pkg::RCW_OUT_POWER: clk_out_next = power_active;
			rcw_pkg::RCW_OUT_STAMP: clk_out_next = stamp_event;
			default: clk_out_next = 1'b0;
		endcase
		// Polarity one drives the active level high
		pwc_next = ctrl_next.power_ctl_function_enable ? ctrl_next.power_ctl_polarity :
			!ctrl_next.power_ctl_polarity;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clk_out_reg <= 1'b0;
			clk_oe_reg <= 1'b0;
			pwc_reg <= 1'b0;
			pwc_oe_reg <= 1'b0;
		end else begin
			clk_out_reg <= clk_out_next;
			clk_oe_reg <= ctrl_next.clock_output_enable;
			pwc_reg <= pwc_next;
			pwc_oe_reg <= ctrl_next.power_ctl_pin_enable;
		end
	end

	// Read port: data stand for exactly one cycle after the strobe
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	always_comb begin
		rdata_next = 32'h0;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				`RCW_OFS_CTRL_LOW: rdata_next = {16'h0, ctrl_reg};
				`RCW_OFS_CTRL_TWO: rdata_next = {30'h0, src_reg};
				`RCW_OFS_TIME: rdata_next = time_reg;
				`RCW_OFS_IRQ_STATUS: rdata_next = {28'h0, status_reg};
				`RCW_OFS_IRQ_MASK: rdata_next = {28'h0, mask_reg};
				`RCW_OFS_ALARM: rdata_next = alarm_reg;
				`RCW_OFS_STAMP: rdata_next = stamp_reg;
				default: rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign bus_rdata = rdata_reg;
	assign clock_out = clk_out_reg;
	assign clock_out_oe = clk_oe_reg;
	assign power_ctl_out = pwc_reg;
	assign power_ctl_out_oe = pwc_oe_reg;
	assign irq = irq_reg;

endmodule

/* rcw_top_properties.sv */
// Port-level assertions for the control word block
`timescale 1ns/100ps
`include "rcw_consts.svh"
module rcw_top_properties (
	input wire logic clk_sys,
	input wire logic resetn,
	input rcw_pkg::rcw_bus_req_type bus_req,
	input wire logic [31:0] bus_rdata,
	input wire logic clock_out,
	input wire logic clock_out_oe,
	input wire logic power_ctl_out,
	input wire logic power_ctl_out_oe,
	input wire logic irq
);
	logic [15:0] ctl_reg;
	logic [15:0] ctl_next;
	logic [2:0] quiet_reg;
	logic [2:0] quiet_next;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence ctrl_wr;
		bus_req.wr && bus_req.addr == `RCW_OFS_CTRL_LOW;
	endsequence
	sequence ctrl_idle;
		!(bus_req.wr && bus_req.addr == `RCW_OFS_CTRL_LOW);
	endsequence
	sequence reg_rd(logic [7:0] a);
		bus_req.rd && bus_req.addr == a;
	endsequence
	// Output bits 10..7 take every write, so the written word is a safe reference
	always_comb begin
		ctl_next = ctl_reg;
		quiet_next = quiet_reg;
		if (bus_req.wr && bus_req.addr == `RCW_OFS_CTRL_LOW) begin
			ctl_next = bus_req.wdata[15:0];
			quiet_next = 3'h0;
		end else if (quiet_reg != 3'h7) begin
			quiet_next = quiet_reg + 3'h1;
		end
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctl_reg <= 16'h0;
			quiet_reg <= 3'h0;
		end else begin
			ctl_reg <= ctl_next;
			quiet_reg <= quiet_next;
		end
	end
	rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 32'h0)
		else $error("read data not zero outside read");
	ctrl_resv_a: assert property (reg_rd(`RCW_OFS_CTRL_LOW) |=> (bus_rdata & 32'hffff700e) == 0)
		else $error("reserved control bits read nonzero");
	src_resv_a: assert property (reg_rd(`RCW_OFS_CTRL_TWO) |=> bus_rdata[31:2] == 30'h0)
		else $error("source select upper bits nonzero");
	key_read_a: assert property (reg_rd(`RCW_OFS_KEY) |=> bus_rdata == 32'h0)
		else $error("key register readable");
	pin_oe_a: assert property (quiet_reg == 3'h4 |-> power_ctl_out_oe == ctl_reg[8])
		else $error("power pin enable mismatch");
	clk_oe_a: assert property (ctrl_wr ##1 ctrl_idle [*4] |-> clock_out_oe == ctl_reg[7])
		else $error("clock output enable mismatch");
	pwr_level_a: assert property (quiet_reg[2] |-> power_ctl_out == (ctl_reg[10] ? ctl_reg[9] : !ctl_reg[9]))
		else $error("power control level mismatch");
	unused_sel_a: assert property (quiet_reg == 3'h7 && ctl_reg[6:4] > 3'h4 |-> !clock_out)
		else $error("unused select drives clock output");
	reset_quiet_a: assert property (disable iff (1'b0) !resetn && !$past(resetn)
		|-> !clock_out && !power_ctl_out && !power_ctl_out_oe && !irq)
		else $error("outputs active during reset");
endmodule

bind rcw_top rcw_top_properties rcw_top_properties_inst (.clk_sys(clk_sys), .resetn(resetn),
	.bus_req(bus_req), .bus_rdata(bus_rdata), .clock_out(clock_out), .clock_out_oe(clock_out_oe),
	.power_ctl_out(power_ctl_out), .power_ctl_out_oe(power_ctl_out_oe), .irq(irq));

/* tb_rcw_top.sv */
// Self-checking bench for the control word block
`timescale 1ns/100ps
`include "rcw_consts.svh"
module tb_rcw_top;
	logic clk_sys = 1'b0;
	logic resetn = 1'b1;
	rcw_pkg::rcw_bus_req_type bus_req = '0;
	logic [31:0] bus_rdata;
	logic [2:0] ref_pins = 3'h0;
	logic stamp_n_pin = 1'b1;
	logic clock_out, clock_out_oe, power_ctl_out, power_ctl_out_oe, irq;
	logic [31:0] rd_val, w, t0;
	logic [15:0] shadow = 16'h0;
	logic [1:0] src = 2'h0;
	logic opn, seen;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	// Short second so counting shows within a few hundred cycles
	rcw_top #(.SYS_TICKS_PER_SEC(32'h8)) rcw_top_inst (.clk_sys(clk_sys), .resetn(resetn),
		.bus_req(bus_req), .bus_rdata(bus_rdata), .crystal_clk_pin(ref_pins[0]),
		.low_power_rc_osc_clk_pin(ref_pins[1]), .mains_clk_pin(ref_pins[2]), .stamp_n_pin(stamp_n_pin),
		.clock_out(clock_out), .clock_out_oe(clock_out_oe), .power_ctl_out(power_ctl_out),
		.power_ctl_out_oe(power_ctl_out_oe), .irq(irq));
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		ref_pins <= 3'($urandom);
		cyc++;
		if (cyc == 4000) begin
			n_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("Errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus_req.wr <= 1'b1;
		bus_req.addr <= a;
		bus_req.wdata <= d;
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
	endtask
	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		bus_req.rd <= 1'b1;
		bus_req.addr <= a;
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		#1 d = bus_rdata;
	endtask
	task automatic unlock();
		bus_write(`RCW_OFS_KEY, {24'h0, `RCW_KEY_FIRST});
		bus_write(`RCW_OFS_KEY, {24'h0, `RCW_KEY_SECOND});
	endtask
	task automatic stamp_pulse(output logic hit);
		hit = 1'b0;
		stamp_n_pin <= 1'b0;
		for (int k = 0; k < 12; k++) begin
			@(posedge clk_sys);
			if (k == 3)
				stamp_n_pin <= 1'b1;
			#1 hit = hit | clock_out;
		end
	endtask
	function automatic logic [15:0] ctrl_exp(input logic [15:0] old, input logic [31:0] d,
		input logic open);
		ctrl_exp = d[15:0] & `RCW_CTRL_LOW_WMASK;
		if (old[11])
			ctrl_exp[15] = old[15];
		if (old[11] && !open)
			ctrl_exp[11] = 1'b1;
	endfunction
	initial begin
		void'($urandom(32'hd65a));
		// A real falling edge, so the asynchronous reset acts before the first clock
		#1 resetn <= 1'b0;
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		bus_read(`RCW_OFS_CTRL_LOW, rd_val);
		check("ctrl reset", rd_val, 32'h0);
		for (int i = 0; i < 16; i++) begin
			w = $urandom;
			opn = shadow[11] && $urandom_range(1);
			if (opn)
				unlock();
			bus_write(`RCW_OFS_CTRL_LOW, w);
			shadow = ctrl_exp(shadow, w, opn);
			bus_read(`RCW_OFS_CTRL_LOW, rd_val);
			check("ctrl", rd_val, {16'h0, shadow});
			check("pwr", {31'h0, power_ctl_out}, {31'h0, shadow[10] ~^ shadow[9]});
			check("pwr oe", {31'h0, power_ctl_out_oe}, {31'h0, shadow[8]});
			w = $urandom;
			bus_write(`RCW_OFS_CTRL_TWO, w);
			if (!shadow[11])
				src = w[1:0];
			bus_read(`RCW_OFS_CTRL_TWO, rd_val);
			check("src", rd_val, {30'h0, src});
		end
		if (shadow[11])
			unlock();
		bus_write(`RCW_OFS_CTRL_LOW, 32'h0);
		bus_write(`RCW_OFS_CTRL_TWO, 32'h3);
		t0 = 32'($urandom_range(16'hffff));
		bus_write(`RCW_OFS_TIME, t0);
		bus_write(`RCW_OFS_CTRL_LOW, 32'h8000);
		repeat (80) @(posedge clk_sys);
		bus_read(`RCW_OFS_TIME, rd_val);
		check("running", {31'h0, rd_val >= t0 + 8 && rd_val <= t0 + 12}, 32'h1);
		bus_write(`RCW_OFS_CTRL_LOW, 32'h0);
		bus_read(`RCW_OFS_TIME, t0);
		repeat (40) @(posedge clk_sys);
		bus_read(`RCW_OFS_TIME, rd_val);
		check("stopped", rd_val, t0);
		bus_write(`RCW_OFS_CTRL_LOW, 32'h0800);
		bus_write(`RCW_OFS_TIME, ~t0);
		bus_write(`RCW_OFS_CTRL_TWO, 32'h0);
		bus_write(`RCW_OFS_ALARM, 32'h5a);
		bus_write(`RCW_OFS_CTRL_LOW, 32'h8000);
		bus_read(`RCW_OFS_TIME, rd_val);
		check("locked time", rd_val, t0);
		bus_read(`RCW_OFS_CTRL_TWO, rd_val);
		check("locked src", rd_val, 32'h3);
		bus_read(`RCW_OFS_ALARM, rd_val);
		check("alarm", rd_val, 32'h5a);
		bus_read(`RCW_OFS_CTRL_LOW, rd_val);
		check("no key", rd_val, 32'h0800);
		unlock();
		repeat (8) @(posedge clk_sys);
		bus_write(`RCW_OFS_CTRL_LOW, 32'h0);
		bus_read(`RCW_OFS_CTRL_LOW, rd_val);
		check("late clear", rd_val, 32'h0800);
		unlock();
		bus_write(`RCW_OFS_CTRL_LOW, 32'h0);
		bus_read(`RCW_OFS_CTRL_LOW, rd_val);
		check("unlocked", rd_val, 32'h0);
		bus_write(`RCW_OFS_IRQ_MASK, 32'h0);
		bus_write(`RCW_OFS_IRQ_STATUS, 32'hf);
		bus_write(`RCW_OFS_CTRL_LOW, 32'h00c1);
		stamp_pulse(seen);
		check("stamp out", {31'h0, seen}, 32'h1);
		bus_read(`RCW_OFS_IRQ_STATUS, rd_val);
		check("stamp flag", {31'h0, rd_val[2]}, 32'h1);
		check("irq masked", {31'h0, irq}, 32'h0);
		bus_write(`RCW_OFS_IRQ_MASK, 32'h4);
		repeat (2) @(posedge clk_sys);
		#1 check("irq on", {31'h0, irq}, 32'h1);
		bus_write(`RCW_OFS_IRQ_STATUS, 32'h4);
		repeat (2) @(posedge clk_sys);
		#1 check("irq off", {31'h0, irq}, 32'h0);
		bus_read(`RCW_OFS_STAMP, rd_val);
		check("stamp value", rd_val, t0);
		for (int k = 5; k < 8; k++) begin
			bus_write(`RCW_OFS_CTRL_LOW, {24'h0, 1'b1, k[2:0], 4'h1});
			stamp_pulse(seen);
			check("unused sel", {31'h0, seen}, 32'h0);
		end
		bus_write(`RCW_OFS_CTRL_LOW, 32'h04b0);
		repeat (3) @(posedge clk_sys);
		#1 check("power sel", {31'h0, clock_out}, 32'h1);
		bus_read(8'h20, rd_val);
		check("unmapped", rd_val, 32'h0);
		bus_write(`RCW_OFS_TIME, 32'h100);
		bus_write(`RCW_OFS_ALARM, 32'h101);
		bus_write(`RCW_OFS_CTRL_LOW, 32'h8080);
		stamp_pulse(seen);
		check("alarm out", {31'h0, seen}, 32'h1);
		bus_read(`RCW_OFS_IRQ_STATUS, rd_val);
		check("alarm flag", {31'h0, rd_val[1]}, 32'h1);
		// The half-second square toggles once in every four system ticks
		bus_write(`RCW_OFS_CTRL_LOW, 32'h8090);
		@(posedge clk_sys);
		#1 seen = clock_out;
		repeat (4) @(posedge clk_sys);
		#1 check("second out", {31'h0, clock_out}, {31'h0, !seen});
		bus_write(`RCW_OFS_CTRL_LOW, 32'h00a0);
		repeat (2) @(posedge clk_sys);
		#1 check("tick out", {31'h0, clock_out}, 32'h1);
		check("clk oe", {31'h0, clock_out_oe}, 32'h1);
		bus_write(`RCW_OFS_CTRL_LOW, 32'h0800);
		resetn <= 1'b0;
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		bus_read(`RCW_OFS_CTRL_LOW, rd_val);
		check("lock after reset", rd_val, 32'h0);
		complete_run();
	end
endmodule
